// file: verilog/swr_pkg.sv
// Purpose: Shared constants for the supervisor reset and watchdog block
// Assumes: 125 MHz system clock; times are kept in their own units
// Notes: Cycle counts are derived from the times and the clock rate

package swr_pkg;

	// ************************************************************
	// Clock rate
	// ************************************************************
	localparam int unsigned SWR_CLK_KHZ = 125000;

	// ************************************************************
	// Times as specified
	// ************************************************************
	localparam int unsigned SWR_HOLD_MS = 200;
	localparam int unsigned SWR_DOG_MS = 1600;
	localparam int unsigned SWR_GLITCH_US = 15;
	localparam int unsigned SWR_MR_IGNORE_NS = 100;
	localparam int unsigned SWR_MR_ACCEPT_NS = 1000;

	// ************************************************************
	// Derived cycle counts
	// ************************************************************
	// Hold and timeout are least times: exact here, no rounding needed
	localparam int unsigned SWR_HOLD_CYCLES = SWR_HOLD_MS * SWR_CLK_KHZ;
	localparam int unsigned SWR_DOG_CYCLES = SWR_DOG_MS * SWR_CLK_KHZ;
	// Longest ignored dip, rounded down
	localparam int unsigned SWR_GLITCH_CYCLES =
		(SWR_GLITCH_US * SWR_CLK_KHZ) / 1000;
	// Longest ignored manual pulse, rounded down
	localparam int unsigned SWR_MR_IGNORE_CYCLES =
		(SWR_MR_IGNORE_NS * SWR_CLK_KHZ) / 1000000;
	// Shortest accepted manual pulse, rounded up
	localparam int unsigned SWR_MR_ACCEPT_CYCLES =
		(SWR_MR_ACCEPT_NS * SWR_CLK_KHZ + 999999) / 1000000;
	// Filters need a level stable one cycle beyond the ignored span
	localparam int unsigned SWR_SUPPLY_FILT = SWR_GLITCH_CYCLES + 1;
	localparam int unsigned SWR_MR_FILT = SWR_MR_IGNORE_CYCLES + 1;

	// ************************************************************
	// Levels after reset
	// ************************************************************
	localparam logic SWR_SUPPLY_LOW_RST = 1'b0;
	localparam logic SWR_MR_N_RST = 1'b1;

endpackage : swr_pkg

// file: verilog/swr_filt_if.sv
// Purpose: Carrier between the main block and a level filter
// Assumes: One clock domain
// Notes: raw goes in, clean comes back

`timescale 1ns/10ps
`default_nettype none

interface swr_filt_if;
	logic raw;
	logic clean;
	modport filt (input raw, output clean);
	modport user (output raw, input clean);
endinterface : swr_filt_if

`default_nettype wire

// file: verilog/swr_level_filter.sv
// Purpose: Passes a level only after it has been stable for a set count
// Assumes: Input synchronous to clock
// Notes: Rejects glitches and switch bounce on both edges

`timescale 1ns/10ps
`default_nettype none

module swr_level_filter
	import swr_pkg::*;
#(
	parameter int unsigned COUNT = 2,
	parameter logic RESET_LEVEL = 1'b0
) (
	input wire logic clock,
	input wire logic reset,
	swr_filt_if.filt port
);

	localparam int CW = $clog2(COUNT + 1);

	typedef struct packed {
		logic level;
		logic [CW-1:0] cnt;
	} swr_filt_state_t;

	swr_filt_state_t state;
	swr_filt_state_t next_state;

	// ************************************************************
	// Stability counter
	// ************************************************************
	always_comb begin
		next_state = state;
		if (port.raw == state.level) begin
			next_state.cnt = '0;
		end else if (state.cnt == CW'(COUNT - 1)) begin
			// Stable long enough: take the new level
			next_state.level = port.raw;
			next_state.cnt = '0;
		end else begin
			next_state.cnt = state.cnt + CW'(1);
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state <= '{level: RESET_LEVEL, cnt: '0};
		end else begin
			state <= next_state;
		end
	end

	assign port.clean = state.level;

	// ************************************************************
	// Checks
	// ************************************************************
	a_filter_stable: assert property (@(posedge clock) disable iff (reset)
		$changed(state.level) |-> $past(port.raw, 1) == state.level)
		else $error("Filter changed level without a stable input");

endmodule : swr_level_filter

`default_nettype wire

// file: verilog/swr_supervisor.sv
// Purpose: Supervisory reset generator with watchdog and manual reset
// Assumes: Supply comparator and pins sampled synchronously to clock
// Notes: Long counts are parameters so simulation can shorten them

`timescale 1ns/10ps
`default_nettype none

module swr_supervisor
	import swr_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = SWR_HOLD_CYCLES,
	parameter int unsigned DOG_CYCLES = SWR_DOG_CYCLES,
	parameter int unsigned SUPPLY_FILT = SWR_SUPPLY_FILT,
	parameter int unsigned MR_FILT = SWR_MR_FILT
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic supply_low,
	input wire logic manual_clear_n,
	input wire logic kick_input_in,
	output logic kick_input_out,
	output logic kick_input_oe,
	output logic reset_n_out,
	output logic reset_out
);

	// ************************************************************
	// Widths and derived points
	// ************************************************************
	localparam int HW = $clog2(HOLD_CYCLES + 1);
	localparam int DW = $clog2(DOG_CYCLES + 1);
	// Internal drive goes high for the last eighth of the timeout
	localparam int unsigned DOG_HIGH = DOG_CYCLES - DOG_CYCLES / 8;

	typedef struct packed {
		logic [HW-1:0] hold;
		logic [DW-1:0] dog;
		logic kick_prev;
		logic kick_drive;
		logic rst_n;
	} swr_state_t;

	swr_state_t state;
	swr_state_t next_state;

	// ************************************************************
	// Input filters
	// ************************************************************
	swr_filt_if supply_if ();
	swr_filt_if mr_if ();

	assign supply_if.raw = supply_low;
	// Pin pull-up makes an open input arrive here as high
	assign mr_if.raw = manual_clear_n;

	// Short dips are absorbed; only a sustained brownout counts
	swr_level_filter #(
		.COUNT(SUPPLY_FILT),
		.RESET_LEVEL(SWR_SUPPLY_LOW_RST)
	) u_supply_filter (
		.clock(clock),
		.reset(reset),
		.port(supply_if.filt)
	);

	// Bounce and noise pulses never reach the hold logic
	swr_level_filter #(
		.COUNT(MR_FILT),
		.RESET_LEVEL(SWR_MR_N_RST)
	) u_mr_filter (
		.clock(clock),
		.reset(reset),
		.port(mr_if.filt)
	);

	logic supply_bad;
	logic manual_active;
	logic trig_level;
	logic kick_edge;
	logic dog_expire;

	assign supply_bad = supply_if.clean;
	assign manual_active = !mr_if.clean;
	assign trig_level = supply_bad | manual_active;

	// Inputs are synchronous, so any level held one cycle is an edge
	assign kick_edge = kick_input_in != state.kick_prev;
	assign dog_expire = state.rst_n && !kick_edge &&
		(state.dog == DW'(DOG_CYCLES - 1));

	// ************************************************************
	// Reset hold and watchdog
	// ************************************************************
	always_comb begin
		next_state = state;
		next_state.kick_prev = kick_input_in;

		// Level triggers reload the timer each cycle, so the full hold
		// always follows the last dip or the manual release
		if (trig_level || dog_expire) begin
			next_state.hold = HW'(HOLD_CYCLES);
		end else if (state.hold != '0) begin
			next_state.hold = state.hold - HW'(1);
		end
		next_state.rst_n = (next_state.hold == '0);

		if (!state.rst_n || kick_edge || dog_expire) begin
			next_state.dog = '0;
		end else begin
			next_state.dog = state.dog + DW'(1);
		end

		// Weak drive makes an open pin toggle itself before expiry
		next_state.kick_drive = (next_state.dog >= DW'(DOG_HIGH));
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			// Start as a power-on: a full hold period before release
			state <= '{hold: HW'(HOLD_CYCLES), dog: '0, kick_prev: 1'b0,
				kick_drive: 1'b0, rst_n: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign reset_n_out = state.rst_n;
	// Both come from one flop, so they can never disagree
	assign reset_out = !state.rst_n;
	assign kick_input_out = state.kick_drive;
	// The drive is weak; a host driver overrides it at the pin
	assign kick_input_oe = 1'b1;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	a_outputs_inverse: assert property (
		reset_out == !reset_n_out)
		else $error("Reset outputs are not inverse");

	a_brownout_holds: assert property (
		supply_bad |=> !reset_n_out && state.hold == HW'(HOLD_CYCLES))
		else $error("Reset not held during brownout");

	a_hold_restart: assert property (
		$rose(supply_bad) |=> state.hold == HW'(HOLD_CYCLES))
		else $error("Hold timer not restarted on a dip");

	a_manual_holds: assert property (
		manual_active |=> !reset_n_out && state.hold == HW'(HOLD_CYCLES))
		else $error("Reset not held during manual reset");

	a_hold_countdown: assert property (
		!trig_level && !dog_expire && state.hold != '0
		|=> state.hold == $past(state.hold) - HW'(1))
		else $error("Hold timer did not count down");

	a_release_end: assert property (
		!trig_level && state.hold == HW'(1) ##1 !trig_level
		|-> reset_n_out ##1 (reset_n_out || $past(trig_level || dog_expire)))
		else $error("Reset not released at end of hold");

	a_dog_cleared: assert property (
		!reset_n_out |=> state.dog == '0)
		else $error("Watchdog counted during reset");

	a_dog_edge_clear: assert property (
		kick_edge |=> state.dog == '0)
		else $error("Watchdog not cleared by kick edge");

	a_dog_expiry: assert property (
		dog_expire |=> !reset_n_out ##1 !reset_n_out)
		else $error("Watchdog expiry did not assert reset");

	a_dog_counts: assert property (
		reset_n_out && !kick_edge && !dog_expire
		|=> state.dog == $past(state.dog) + DW'(1))
		else $error("Watchdog did not count while released");

	a_kick_drive: assert property (
		$rose(kick_input_out) |-> state.dog == DW'(DOG_HIGH))
		else $error("Kick drive rose at the wrong count");

	c_brownout: cover property (supply_bad ##1 !supply_bad);
	c_manual: cover property (manual_active ##1 !manual_active);
	c_dog_expire: cover property (dog_expire);
	c_kick_clear: cover property (reset_n_out && kick_edge);

endmodule : swr_supervisor

`default_nettype wire

// file: test/swr_host_model.sv
// Purpose: Host processor on the far side of the kick pin
// Assumes: Host drive overrides the weak internal drive when enabled
// Notes: serve gives a short high pulse early in each period

`timescale 1ns/10ps
`default_nettype none

module swr_host_model (
	input wire logic clock,
	input wire logic reset,
	input wire logic drive_en,
	input wire logic serve,
	input wire logic level,
	input wire logic weak_out,
	output logic pin
);
	logic [7:0] tick;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			tick <= 8'h00;
		end else begin
			tick <= (tick == 8'hc7) ? 8'h00 : tick + 8'h01;
		end
	end

	// Pulse 8 cycles wide, well inside the first 7/8 of the timeout
	assign pin = drive_en ? (serve ? (tick < 8'h08) : level)
		: weak_out;
endmodule : swr_host_model

`default_nettype wire

// file: test/swr_supervisor_tb.sv
// Purpose: Self-checking bench for the supervisor reset block
// Assumes: Shortened counts: hold 100, timeout 400, filters 8 and 13
// Notes: Rise and fall times are checked inside a small tolerance

`timescale 1ns/10ps
`default_nettype none

module swr_supervisor_tb;
	localparam int H = 100;
	localparam int D = 400;
	localparam int SF = 8;
	localparam int MF = 13;
	logic clock, reset, supply_low, manual_clear_n;
	logic drive_en, serve, level, pin, kout, koe, reset_n_out, reset_out;
	int mismatches, num_checks, cycles, falls, rises, n, r0;
	logic seen_hi;

	swr_supervisor #(.HOLD_CYCLES(H), .DOG_CYCLES(D), .SUPPLY_FILT(SF),
		.MR_FILT(MF)) uut (.clock(clock), .reset(reset),
		.supply_low(supply_low), .manual_clear_n(manual_clear_n),
		.kick_input_in(pin), .kick_input_out(kout), .kick_input_oe(koe),
		.reset_n_out(reset_n_out), .reset_out(reset_out));
	swr_host_model host (.clock(clock), .reset(reset), .drive_en(drive_en),
		.serve(serve), .level(level), .weak_out(kout), .pin(pin));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop

	always @(posedge clock) begin
		cycles++;
		if (cycles >= 10000) begin
			mismatches++;
			report_and_stop();
		end
	end
	always @(negedge reset_n_out) falls++;
	always @(posedge reset_n_out) rises++;
	// Weak high lasts one cycle: look away from the edge that launches it
	always @(negedge clock) begin
		if (kout === 1'b1) seen_hi = 1'b1;
		chk("reset_out", !reset_n_out, reset_out);
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (e !== g) begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	task chk_rng(input string nm, input int lo, input int hi, input int v);
		num_checks++;
		if (v < lo || v > hi) begin
			mismatches++;
			$display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, v);
		end
	endtask : chk_rng

	task cyc(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : cyc

	task wait_rn(input logic v, input int lim);
		n = 0;
		while (reset_n_out !== v && n < lim) begin
			cyc(1);
			n++;
		end
	endtask : wait_rn

	task quiet(input string nm, input int k);
		r0 = falls;
		cyc(k);
		chk(nm, r0, falls);
	endtask : quiet

	task t_supply;
		supply_low = 1'b1;
		cyc(SF - 1);
		supply_low = 1'b0;
		quiet("short dip", 40);
		supply_low = 1'b1;
		cyc(20);
		chk("low in dip", 1'b0, reset_n_out);
		supply_low = 1'b0;
		r0 = rises;
		cyc(50);
		supply_low = 1'b1;
		cyc(20);
		supply_low = 1'b0;
		wait_rn(1'b1, 300);
		chk_rng("dip hold", H + SF - 2, H + SF + 4, n);
		chk("one release", r0 + 1, rises);
	endtask : t_supply

	task t_manual;
		manual_clear_n = 1'b0;
		cyc(MF - 1);
		manual_clear_n = 1'b1;
		quiet("short manual", 40);
		r0 = rises;
		manual_clear_n = 1'b0;
		cyc(30);
		chk("manual low", 1'b0, reset_n_out);
		repeat (3) begin
			manual_clear_n = 1'b1;
			cyc(4);
			manual_clear_n = 1'b0;
			cyc(4);
		end
		manual_clear_n = 1'b1;
		wait_rn(1'b1, 300);
		chk_rng("manual hold", H + MF - 2, H + MF + 4, n);
		chk("bounce release", r0 + 1, rises);
	endtask : t_manual

	task t_dog;
		drive_en = 1'b1;
		manual_clear_n = 1'b0;
		cyc(20);
		manual_clear_n = 1'b1;
		repeat (2) begin
			// Stuck high first, then stuck low; changed while still in reset
			level = ~level;
			wait_rn(1'b1, 300);
			wait_rn(1'b0, 600);
			chk_rng("dog expiry", D - 2, D + 3, n);
		end
		drive_en = 1'b0;
		wait_rn(1'b1, 300);
		chk("dog release", 1'b1, reset_n_out);
		chk("weak oe", 1'b1, koe);
		drive_en = 1'b1;
		serve = 1'b1;
		quiet("serviced", 1200);
		serve = 1'b0;
		drive_en = 1'b0;
		seen_hi = 1'b0;
		quiet("open pin", 1200);
		chk("weak high", 1'b1, seen_hi);
	endtask : t_dog

	initial begin
		reset = 1'b1;
		supply_low = 1'b0;
		manual_clear_n = 1'b1;
		drive_en = 1'b0;
		serve = 1'b0;
		level = 1'b0;
		seen_hi = 1'b0;
		cyc(12);
		reset = 1'b0;
		wait_rn(1'b1, 200);
		chk_rng("power hold", H - 1, H + 3, n);
		t_supply();
		t_manual();
		t_dog();
		report_and_stop();
	end
endmodule : swr_supervisor_tb

`default_nettype wire
